// file: pmfs_regs.v
// monitor assignment, core buck settings, scratch, identity and fail-safe flags/reactions
`include "pmfs_regs_defs.vh"

module pmfs_regs #(
  parameter [3:0] DEVICE_CODE   = 4'h5,  // arbitrary value
  parameter [3:0] FAMILY_CODE   = 4'ha,  // arbitrary value
  parameter [2:0] METAL_REV     = 3'h2,  // arbitrary value
  parameter [2:0] FULL_MASK_REV = 3'h3   // arbitrary value
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [7:0]  regAddr,
  input  wire        regWrite,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  input  wire [7:0]  otpStandbyCode,
  input  wire        fault_input1,
  input  wire        fault_input2,
  input  wire        wakeFromStandbyEvt,
  input  wire        standbyWindowErrEvt,
  input  wire [3:0]  monitorFail,
  input  wire        power_good_diag_fail,
  input  wire        reset_out_diag_fail,
  input  wire        failsafe_out_diag_fail,
  input  wire        watchdogBadRefresh,
  input  wire        commFailure,
  input  wire [5:0]  voltageFaultEvt,
  output wire [11:0] monitorSourceSel,
  output wire [6:0]  core_buck_offset_code,
  output wire [7:0]  core_buck_standby_code,
  output reg         reset_output_pin,
  output reg         failsafe_output_pin
);

  reg  [11:0] monSel_q;
  reg  [6:0]  offset_q;
  reg  [7:0]  stby_q;
  reg         stbyLoaded_q;
  reg  [15:0] scratch_a_q;
  reg  [15:0] scratch_b_q;
  reg  [11:0] react_q;
  reg         wake_q;
  reg         stbyErr_q;
  reg  [1:0]  finMeta_q;
  reg  [1:0]  fin_q;
  reg  [3:0]  grp_q;
  reg         rstReq_d;
  reg         fsReq_d;
  wire [15:0] identWord;
  wire [15:0] flagsWord;
  wire [1:0]  reactCode [0:5];
  wire        wrFlags;

  assign monitorSourceSel       = monSel_q;
  assign core_buck_offset_code  = offset_q;
  assign core_buck_standby_code = stby_q;
  assign wrFlags = regWrite && (regAddr == `PMFS_ADDR_FLAGS);

  // identity is wired, never stored; reserved bits 15 and 11 stay zero
  assign identWord = {1'b0, FULL_MASK_REV, 1'b0, METAL_REV, FAMILY_CODE, DEVICE_CODE};

  assign flagsWord = {grp_q, stbyErr_q, wake_q, fin_q, 8'h00};

  // writable fields; writes to read-only or unmapped addresses fall through
  always @(posedge clk) begin
    if (!reset_n) begin
      monSel_q     <= `PMFS_MONSEL_RST;
      offset_q     <= `PMFS_OFFSET_RST;
      scratch_a_q  <= `PMFS_SCR_RST;
      scratch_b_q  <= `PMFS_SCR_RST;
      react_q      <= `PMFS_REACT_RST;
      stbyLoaded_q <= 1'b0;
    end else begin
      if (regWrite && regAddr == `PMFS_ADDR_MONSEL) begin
        monSel_q <= regWdata[11:0];
      end else if (regWrite && regAddr == `PMFS_ADDR_OFFSET) begin
        offset_q <= regWdata[6:0];
      end else if (regWrite && regAddr == `PMFS_ADDR_SCRA) begin
        scratch_a_q <= regWdata;
      end else if (regWrite && regAddr == `PMFS_ADDR_SCRB) begin
        scratch_b_q <= regWdata;
      end else if (regWrite && regAddr == `PMFS_ADDR_REACT) begin
        react_q <= regWdata[11:0];
      end
      stbyLoaded_q <= 1'b1;
    end
  end

  // otp value is a port, so it is caught on the first clock after release
  always @(posedge clk) begin
    if (!reset_n) begin
      stby_q <= `PMFS_STBY_RST;
    end else if (!stbyLoaded_q) begin
      stby_q <= otpStandbyCode;
    end else if (regWrite && regAddr == `PMFS_ADDR_STBY) begin
      stby_q <= regWdata[7:0];
    end
  end

  // sticky flags: a new event beats a simultaneous write-one clear
  always @(posedge clk) begin
    if (!reset_n) begin
      wake_q    <= 1'b0;
      stbyErr_q <= 1'b0;
    end else begin
      if (wakeFromStandbyEvt) begin
        wake_q <= 1'b1;
      end else if (wrFlags && regWdata[`PMFS_FLAG_WAKE + 8]) begin
        wake_q <= 1'b0;
      end
      if (standbyWindowErrEvt) begin
        stbyErr_q <= 1'b1;
      end else if (wrFlags && regWdata[`PMFS_FLAG_STBYERR + 8]) begin
        stbyErr_q <= 1'b0;
      end
    end
  end

  // fault inputs are asynchronous pins: two stages before use
  always @(posedge clk) begin
    if (!reset_n) begin
      finMeta_q <= 2'h0;
      fin_q     <= 2'h0;
      grp_q     <= 4'h0;
    end else begin
      finMeta_q <= {fault_input1, fault_input2};
      fin_q     <= finMeta_q;
      grp_q[0]  <= |monitorFail;
      grp_q[1]  <= power_good_diag_fail | reset_out_diag_fail | failsafe_out_diag_fail;
      grp_q[2]  <= watchdogBadRefresh;
      grp_q[3]  <= commFailure;
    end
  end

  // fields in pairs: io uv/ov, hv ldo uv/ov, core uv/ov
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : gReact
      assign reactCode[gi] = voltageFaultEvt[gi] ? react_q[2*gi+1:2*gi] : `PMFS_REACT_NONE;
    end
  endgenerate

  integer k;
  always @* begin
    rstReq_d = 1'b0;
    fsReq_d  = 1'b0;
    for (k = 0; k < 6; k = k + 1) begin
      if (reactCode[k][1]) begin
        rstReq_d = 1'b1;
        fsReq_d  = 1'b1;
      end else if (reactCode[k] == `PMFS_REACT_FS) begin
        fsReq_d = 1'b1;
      end
    end
  end

  // outputs are active-high requests, registered for clean pins
  always @(posedge clk) begin
    if (!reset_n) begin
      reset_output_pin    <= 1'b0;
      failsafe_output_pin <= 1'b0;
    end else begin
      reset_output_pin    <= rstReq_d;
      failsafe_output_pin <= fsReq_d;
    end
  end

  // read data registered; unmapped addresses read zero
  always @(posedge clk) begin
    if (!reset_n) begin
      regRdata <= 16'h0000;
    end else if (regAddr == `PMFS_ADDR_MONSEL) begin
      regRdata <= {4'h0, monSel_q};
    end else if (regAddr == `PMFS_ADDR_OFFSET) begin
      regRdata <= {9'h000, offset_q};
    end else if (regAddr == `PMFS_ADDR_STBY) begin
      regRdata <= {8'h00, stby_q};
    end else if (regAddr == `PMFS_ADDR_SCRA) begin
      regRdata <= scratch_a_q;
    end else if (regAddr == `PMFS_ADDR_SCRB) begin
      regRdata <= scratch_b_q;
    end else if (regAddr == `PMFS_ADDR_IDENT) begin
      regRdata <= identWord;
    end else if (regAddr == `PMFS_ADDR_FLAGS) begin
      regRdata <= flagsWord;
    end else if (regAddr == `PMFS_ADDR_REACT) begin
      regRdata <= {4'h0, react_q};
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule

// file: pmfs_regs_defs.vh
// register offsets, field positions and reset values of the monitor and fail-safe bank
`ifndef PMFS_REGS_DEFS_VH
`define PMFS_REGS_DEFS_VH

`define PMFS_ADDR_MONSEL     8'h16
`define PMFS_ADDR_OFFSET     8'h17
`define PMFS_ADDR_STBY       8'h18
`define PMFS_ADDR_SCRA       8'h19
`define PMFS_ADDR_SCRB       8'h1a
`define PMFS_ADDR_IDENT      8'h1b
`define PMFS_ADDR_FLAGS      8'h40
`define PMFS_ADDR_REACT      8'h41

`define PMFS_MONSEL_RST      12'h000
`define PMFS_OFFSET_RST      7'h00
`define PMFS_SCR_RST         16'h0000
`define PMFS_STBY_RST        8'h00
`define PMFS_REACT_RST       12'h999

`define PMFS_FLAG_GRP_LSB    12
`define PMFS_FLAG_STBYERR    3
`define PMFS_FLAG_WAKE       2
`define PMFS_FLAG_FIN1       1
`define PMFS_FLAG_FIN2       0

`define PMFS_ID_FULL_LSB     12
`define PMFS_ID_METAL_LSB    8
`define PMFS_ID_FAMILY_LSB   4

`define PMFS_REACT_NONE      2'h0
`define PMFS_REACT_FS        2'h1

`endif

// file: pmfs_host.sv
// host model making register writes and reads
module pmfs_host (
  input  wire logic   clk,
  output logic [7:0]  regAddr,
  output logic        regWrite,
  output logic [15:0] regWdata,
  output logic        rdPend
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {regAddr, regWrite, regWdata, rdPend} = 26'h0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 {regAddr, regWrite, regWdata} = {a, 1'b1, d};
    @(posedge clk);
    // released data is inverted so a stale word cannot pass
    #1 {regWrite, regWdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 {regAddr, rdPend} = {a, 1'b1};
    @(posedge clk);
    #1 rdPend = 1'b0;
  endtask
endmodule

// file: pmfs_regs_props.sv
// concurrent checks on the register bank ports
module pmfs_regs_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic [7:0]  otpStandbyCode,
  input wire logic        fault_input1,
  input wire logic [3:0]  monitorFail,
  input wire logic [5:0]  voltageFaultEvt,
  input wire logic [11:0] monitorSourceSel,
  input wire logic [7:0]  core_buck_standby_code,
  input wire logic        reset_output_pin,
  input wire logic        failsafe_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  live_input_a: assert property ((regAddr == 8'h40 && $past(reset_n) && $past(reset_n, 2))
    |=> regRdata[9] == $past(fault_input1, 3)) else $error("live input bit wrong");
  mon_summary_a: assert property ((regAddr == 8'h40 && $past(reset_n))
    |=> regRdata[12] == $past(|monitorFail, 2)) else $error("monitor summary wrong");
  scratch_back_a: assert property ((regWrite && regAddr == 8'h19) ##1 regAddr == 8'h19
    |=> regRdata == $past(regWdata, 2)) else $error("scratch readback wrong");
  reserved_zero_a: assert property (regAddr == 8'h40
    |=> regRdata[7:0] == 8'h00) else $error("reserved flag bits set");
  monsel_out_a: assert property ((regWrite && regAddr == 8'h16)
    |=> monitorSourceSel == $past(regWdata[11:0])) else $error("source select wrong");
  otp_load_a: assert property ($rose(reset_n)
    |=> core_buck_standby_code == $past(otpStandbyCode)) else $error("standby code not loaded");
  quiet_pins_a: assert property (voltageFaultEvt == 6'h00
    |=> !reset_output_pin && !failsafe_output_pin) else $error("pin without fault");
  both_pins_a: assert property (reset_output_pin
    |-> failsafe_output_pin) else $error("reset pin without fail-safe pin");
  read_flags_c: cover property (regAddr == 8'h40 ##1 regRdata[15:12] != 4'h0);
  reset_pin_c: cover property (reset_output_pin);
  fs_only_c: cover property (failsafe_output_pin && !reset_output_pin);
endmodule
bind pmfs_regs pmfs_regs_props pmfs_regs_props_i (.*);

// file: pmfs_regs_tb.sv
// self-checking bench for the monitor and fail-safe register bank
module pmfs_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, regWrite, rdPend, rdLate = 1'b0;
  logic fault_input1 = 1'b0, fault_input2 = 1'b0, wakeFromStandbyEvt = 1'b0;
  logic standbyWindowErrEvt = 1'b0, power_good_diag_fail = 1'b0, reset_out_diag_fail = 1'b0;
  logic failsafe_out_diag_fail = 1'b0, watchdogBadRefresh = 1'b0, commFailure = 1'b0;
  logic reset_output_pin, failsafe_output_pin;
  logic [3:0]  monitorFail = 4'h0;
  logic [5:0]  voltageFaultEvt = 6'h00;
  logic [6:0]  core_buck_offset_code;
  logic [7:0]  regAddr, core_buck_standby_code, otpStandbyCode = 8'h00, addr[9];
  logic [11:0] monitorSourceSel;
  logic [15:0] regWdata, regRdata, d, e, rst[9], mask[9];
  logic [15:0] expQ[$];
  logic [1:0]  code;
  int num_errors = 0, check_count = 0;
  pmfs_regs pmfs_regs_i (.*);
  pmfs_host pmfs_host_i (.*);
  always #5 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [15:0] x);
    expQ.push_back(x);
    pmfs_host_i.rd(a);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) rdLate <= rdPend;
  always @(negedge clk) begin
    if (rdLate === 1'b1) begin
      e = expQ.pop_front();
      cmp("regRdata", e, regRdata);
    end
  end
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(4));
    otpStandbyCode = $urandom;
    addr = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h41, 8'h1b, 8'h55, 8'h40};
    rst = '{16'h0, 16'h0, {8'h0, otpStandbyCode}, 16'h0, 16'h0, 16'h0999, 16'h32a5, 16'h0, 16'h0};
    mask = '{16'h0fff, 16'h007f, 16'h00ff, 16'hffff, 16'hffff, 16'h0fff, 16'h0, 16'h0, 16'h0};
    step(8);
    reset_n = 1'b1;
    step(1);
    cmp("standby", {8'h0, otpStandbyCode}, {8'h0, core_buck_standby_code});
    pmfs_host_i.wr(8'h40, 16'h0c00);
    foreach (addr[i]) chkRd(addr[i], rst[i]);
    foreach (addr[i]) begin
      d = $urandom;
      pmfs_host_i.wr(addr[i], d);
      chkRd(addr[i], (d & mask[i]) | (rst[i] & ~mask[i]));
    end
    for (int c = 0; c < 8; c++) begin
      pmfs_host_i.wr(8'h16, {4'h0, {4{c[2:0]}}});
      cmp("monsel", {4'h0, {4{c[2:0]}}}, {4'h0, monitorSourceSel});
    end
    pmfs_host_i.wr(8'h17, 16'hffff);
    cmp("offset", 16'h007f, {9'h0, core_buck_offset_code});
    {fault_input1, wakeFromStandbyEvt, standbyWindowErrEvt, power_good_diag_fail} = 4'hf;
    {monitorFail, commFailure} = 5'h05;
    step(1);
    {wakeFromStandbyEvt, standbyWindowErrEvt} = 2'b00;
    step(3);
    chkRd(8'h40, 16'hbe00);
    pmfs_host_i.wr(8'h40, 16'h0c00);
    chkRd(8'h40, 16'hb200);
    {fault_input1, fault_input2, power_good_diag_fail, failsafe_out_diag_fail} = 4'b0101;
    {monitorFail, commFailure, watchdogBadRefresh} = 6'b000001;
    step(3);
    chkRd(8'h40, 16'h6100);
    for (int f = 0; f < 6; f++) begin
      for (int k = 0; k < 4; k++) begin
        code = k;
        pmfs_host_i.wr(8'h41, 16'(k) << (2 * f));
        voltageFaultEvt = 6'h01 << f;
        step(2);
        cmp("pins", {14'h0, code[1], code != 2'b00}, {14'h0, reset_output_pin, failsafe_output_pin});
        voltageFaultEvt = 6'h00;
      end
    end
    step(2);
    wrap_up();
  end
endmodule
